// [logic/dmi_mode_prog.sv]
// Purpose: Device-side command decode, mode register storage, DLL lock
//          tracking and burst sequencing for a DDR2-style DRAM.
// Assumes: The link clock is slower than I_CORE_CLK and is oversampled.
// Notes:   Array storage is outside this block; only the access shape is
//          produced on the burst outputs.
`timescale 1ns/1ps

// What this block does
// - Accesses are bursts of four or eight, started by activate then read/write.
// - Activate selects bank and row; read/write selects column and auto precharge.
// - Main register write is all strobes and bank bits low.
// - Main register holds burst length, type, latency, test, DLL reset, recovery.
// - Extended register one write has bank bit zero high, bit one low.
// - Register one holds DLL, drive, termination, latency, calibration, strobes.
// - DLL lock count frozen in self refresh, cleared at exit; reads need 200 clocks (earlier reads still run, flagged on O_READ_EARLY).
// - Extended register two write has bank bit one high, bit zero low.
// - Strobes are differential when register one bit ten is zero.
// - Bank bits of a register write choose which register is written.
module dmi_mode_prog
   import dmi_pkg::*;
(
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic        I_LINK_CLK,
   input  wire logic        I_CKE,
   input  wire logic        I_TERMINATION_CONTROL,
   input  wire dmi_cmd_t    I_CMD,
   output logic [15:0]      O_OPERATING_MODE,
   output logic [15:0]      O_EXT_MODE_ONE,
   output logic [15:0]      O_EXT_MODE_TWO,
   output logic             O_DLL_LOCKED,
   output logic             O_STROBE_DIFF,
   output logic             O_TERM_ON,
   output logic             O_BURST_VALID,
   output logic             O_BURST_WRITE,
   output logic [2:0]       O_BURST_BANK,
   output logic [15:0]      O_BURST_ROW,
   output logic [11:0]      O_BURST_COL,
   output logic             O_AUTO_PRECHARGE,
   output logic             O_READ_EARLY
);

   // =========================================================
   // Input synchronisers
   logic       lclk_s1_r, lclk_s2_r, lclk_s3_r;
   logic       cke_s1_r, cke_s2_r, cke_last_r;
   logic       odt_s1_r, odt_s2_r;
   dmi_cmd_t   cmd_s1_r, cmd_s2_r;
   logic       link_rise;

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         lclk_s1_r <= 1'b0;
         lclk_s2_r <= 1'b0;
         lclk_s3_r <= 1'b0;
         cke_s1_r  <= 1'b0;
         cke_s2_r  <= 1'b0;
         cke_last_r <= 1'b0;
         odt_s1_r  <= 1'b0;
         odt_s2_r  <= 1'b0;
         cmd_s1_r  <= '1;
         cmd_s2_r  <= '1;
      end else begin
         lclk_s1_r <= I_LINK_CLK;
         lclk_s2_r <= lclk_s1_r;
         lclk_s3_r <= lclk_s2_r;
         cke_s1_r  <= I_CKE;
         cke_s2_r  <= cke_s1_r;
         if (link_rise)
            cke_last_r <= cke_s2_r;
         odt_s1_r  <= I_TERMINATION_CONTROL;
         odt_s2_r  <= odt_s1_r;
         cmd_s1_r  <= I_CMD;
         cmd_s2_r  <= cmd_s1_r;
      end
   end

   // Command pins settle a full link half-period before the rising edge,
   // so the synchronised copy is stable when the edge is seen.
   assign link_rise = lclk_s2_r & ~lclk_s3_r;

   // =========================================================
   // Command decode
   logic sel, is_act, is_rd, is_wr, is_mrw, is_sre;
   logic [2:0] cmd_code;

   always_comb begin
      cmd_code = {cmd_s2_r.ras_n, cmd_s2_r.cas_n, cmd_s2_r.we_n};
      sel      = link_rise & ~cmd_s2_r.cs_n & cke_s2_r;
      is_act   = sel & (cmd_code == 3'h3);
      is_rd    = sel & (cmd_code == 3'h5);
      is_wr    = sel & (cmd_code == 3'h4);
      is_mrw   = sel & (cmd_code == 3'h0);
      // Self refresh entry is a refresh taken with clock enable low that
      // was high at the previous link edge, judged on synchronised copies.
      is_sre   = link_rise & ~cmd_s2_r.cs_n & ~cke_s2_r & cke_last_r
                 & (cmd_code == 3'h1);
   end

   // =========================================================
   // Mode registers and DLL
   logic [15:0] mr_r, mr_nxt, e1_r, e1_nxt, e2_r, e2_nxt;
   logic [7:0]  lock_r, lock_nxt;
   logic        dll_on_r, dll_on_nxt;
   logic        self_r, self_nxt;

   always_comb begin
      mr_nxt     = mr_r;
      e1_nxt     = e1_r;
      e2_nxt     = e2_r;
      lock_nxt   = lock_r;
      dll_on_nxt = dll_on_r;
      self_nxt   = self_r;
      // Count first, so a DLL reset on the same link edge wins.
      if (link_rise && dll_on_r && !self_r && lock_r != DLL_LOCK_CNT)
         lock_nxt = lock_r + 8'h01;
      if (is_mrw) begin
         // Every write except one to BANK_EXT3 replaces the whole register.
         unique case (cmd_s2_r.bank_select[1:0])
            BANK_MAIN: begin
               mr_nxt = cmd_s2_r.addr;
               if (cmd_s2_r.addr[MR_DLLR])
                  lock_nxt = '0;
            end
            BANK_EXT1: begin
               e1_nxt     = cmd_s2_r.addr;
               dll_on_nxt = ~cmd_s2_r.addr[E1_DLL_DIS];
               if (cmd_s2_r.addr[E1_DLL_DIS])
                  lock_nxt = '0;
            end
            BANK_EXT2: e2_nxt = cmd_s2_r.addr;
            BANK_EXT3: ;
         endcase
      end
      if (is_sre)
         self_nxt = 1'b1;
      else if (self_r && cke_s2_r) begin
         self_nxt = 1'b0;
         lock_nxt = '0;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         mr_r     <= '0;
         e1_r     <= 16'h0001;
         e2_r     <= '0;
         lock_r   <= '0;
         dll_on_r <= 1'b0;
         self_r   <= 1'b0;
      end else begin
         mr_r     <= mr_nxt;
         e1_r     <= e1_nxt;
         e2_r     <= e2_nxt;
         lock_r   <= lock_nxt;
         dll_on_r <= dll_on_nxt;
         self_r   <= self_nxt;
      end
   end

   // =========================================================
   // Bank open and burst sequencing
   dmi_state_t  st_r, st_nxt;
   logic [15:0] row_r [4];
   logic [15:0] row_nxt [4];
   logic [3:0]  open_r, open_nxt;
   logic [3:0]  beat_r, beat_nxt;
   logic        wr_r, wr_nxt, ap_r, ap_nxt, early_r, early_nxt;
   logic [2:0]  bank_r, bank_nxt;
   logic [11:0] col_r, col_nxt;
   logic [3:0]  blen;

   always_comb begin
      st_nxt    = st_r;
      row_nxt   = row_r;
      open_nxt  = open_r;
      beat_nxt  = beat_r;
      wr_nxt    = wr_r;
      ap_nxt    = ap_r;
      bank_nxt  = bank_r;
      col_nxt   = col_r;
      early_nxt = 1'b0;
      blen = (mr_r[MR_BL_LO +: 3] == BL_EIGHT) ? 4'h8 : 4'h4;
      if (is_act) begin
         row_nxt[cmd_s2_r.bank_select[1:0]] = cmd_s2_r.addr;
         open_nxt[cmd_s2_r.bank_select[1:0]] = 1'b1;
      end
      unique case (st_r)
         DMI_ST_POWER: if (is_mrw) st_nxt = DMI_ST_IDLE;
         DMI_ST_IDLE, DMI_ST_ACTIVE: begin
            st_nxt = (open_r != 4'h0) ? DMI_ST_ACTIVE : DMI_ST_IDLE;
            if ((is_rd || is_wr) && open_r[cmd_s2_r.bank_select[1:0]]) begin
               st_nxt   = DMI_ST_BURST;
               wr_nxt   = is_wr;
               bank_nxt = cmd_s2_r.bank_select;
               col_nxt  = {cmd_s2_r.addr[11], 1'b0, cmd_s2_r.addr[9:0]};
               ap_nxt   = cmd_s2_r.addr[10];
               beat_nxt = '0;
               early_nxt = is_rd && (lock_r != DLL_LOCK_CNT);
            end
            if (is_sre) st_nxt = DMI_ST_SELF;
         end
         DMI_ST_BURST: if (link_rise) begin
            // Two transfers per link clock cycle.
            beat_nxt = beat_r + 4'h2;
            if (beat_r + 4'h2 >= blen) begin
               st_nxt = DMI_ST_ACTIVE;
               if (ap_r) open_nxt[bank_r[1:0]] = 1'b0;
            end
         end
         DMI_ST_SELF: if (cke_s2_r) st_nxt = DMI_ST_IDLE;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_r    <= DMI_ST_POWER;
         row_r   <= '{default: 16'h0000};
         open_r  <= '0;
         beat_r  <= '0;
         wr_r    <= 1'b0;
         ap_r    <= 1'b0;
         bank_r  <= '0;
         col_r   <= '0;
         early_r <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         row_r   <= row_nxt;
         open_r  <= open_nxt;
         beat_r  <= beat_nxt;
         wr_r    <= wr_nxt;
         ap_r    <= ap_nxt;
         bank_r  <= bank_nxt;
         col_r   <= col_nxt;
         early_r <= early_nxt;
      end
   end

   // =========================================================
   // Registered outputs
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_OPERATING_MODE <= '0;
         O_EXT_MODE_ONE   <= '0;
         O_EXT_MODE_TWO   <= '0;
         O_DLL_LOCKED     <= 1'b0;
         O_STROBE_DIFF    <= 1'b1;
         O_TERM_ON        <= 1'b0;
         O_BURST_VALID    <= 1'b0;
         O_BURST_WRITE    <= 1'b0;
         O_BURST_BANK     <= '0;
         O_BURST_ROW      <= '0;
         O_BURST_COL      <= '0;
         O_AUTO_PRECHARGE <= 1'b0;
         O_READ_EARLY     <= 1'b0;
      end else begin
         O_OPERATING_MODE <= mr_r;
         O_EXT_MODE_ONE   <= e1_r;
         O_EXT_MODE_TWO   <= e2_r;
         O_DLL_LOCKED     <= (lock_r == DLL_LOCK_CNT);
         O_STROBE_DIFF    <= ~e1_r[E1_STRB_SE];
         // Termination is off in self refresh.
         O_TERM_ON        <= odt_s2_r & ~self_r
                             & (e1_r[E1_RTT_LO] | e1_r[E1_RTT_HI]);
         O_BURST_VALID    <= (st_r == DMI_ST_BURST);
         O_BURST_WRITE    <= wr_r;
         O_BURST_BANK     <= bank_r;
         O_BURST_ROW      <= row_r[bank_r[1:0]];
         O_BURST_COL      <= col_r;
         O_AUTO_PRECHARGE <= ap_r;
         O_READ_EARLY     <= early_r;
      end
   end
endmodule

// [logic/dmi_pkg.sv]
// Purpose: Shared constants and types for the DRAM mode-programming block.
// Assumes: Commands are sampled on rising edges of the link clock.
// Notes:   Field positions follow the mode register layouts.
package dmi_pkg;
   // =========================================================
   // Command pin group
   typedef struct packed {
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic [2:0] bank_select;
      logic [15:0] addr;
   } dmi_cmd_t;

   typedef enum {
      DMI_ST_POWER,
      DMI_ST_IDLE,
      DMI_ST_ACTIVE,
      DMI_ST_BURST,
      DMI_ST_SELF
   } dmi_state_t;

   // =========================================================
   // Bank codes for register writes
   localparam logic [1:0] BANK_MAIN  = 2'h0;
   localparam logic [1:0] BANK_EXT1  = 2'h1;
   localparam logic [1:0] BANK_EXT2  = 2'h2;
   localparam logic [1:0] BANK_EXT3  = 2'h3;

   // Main register fields.
   localparam int MR_BL_LO = 0;
   localparam int MR_BT    = 3;
   localparam int MR_CL_LO = 4;
   localparam int MR_TM    = 7;
   localparam int MR_DLLR  = 8;
   localparam int MR_WR_LO = 9;
   localparam logic [2:0] BL_FOUR  = 3'h2;
   localparam logic [2:0] BL_EIGHT = 3'h3;

   // Extended register one fields, plus one register two field.
   localparam int E1_DLL_DIS  = 0;
   localparam int E1_HALF_DRV = 1;
   localparam int E1_RTT_LO   = 2;
   localparam int E1_AL_LO    = 3;
   localparam int E1_RTT_HI   = 6;
   localparam int E1_CAL_LO   = 7;
   localparam int E1_STRB_SE  = 10;
   localparam int E1_READ_STROBE_COPY_EN  = 11;
   localparam int E2_HOT_SR   = 7;

   // Timing.
   localparam int  CLK_PERIOD_NS   = 50;
   localparam int  DLL_LOCK_CYCLES = 200;
   localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CYCLES);
   localparam int  BURST_MAX       = 8;
endpackage

// [tb/dmi_chk_properties.sv]
// Purpose: Concurrent checks on the ports of the mode-programming block.
// Assumes: Each link period spans several core clocks.
// Notes:   Link edges are found again here with a short sampler.
`timescale 1ns/1ps
module dmi_chk_properties
   import dmi_pkg::*;
(
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic        I_LINK_CLK,
   input  wire logic        I_CKE,
   input  wire logic        I_TERMINATION_CONTROL,
   input  wire logic [15:0] O_OPERATING_MODE,
   input  wire logic [15:0] O_EXT_MODE_ONE,
   input  wire logic [15:0] O_EXT_MODE_TWO,
   input  wire logic        O_DLL_LOCKED,
   input  wire logic        O_STROBE_DIFF,
   input  wire logic        O_TERM_ON,
   input  wire logic        O_BURST_VALID,
   input  wire logic        O_READ_EARLY
);
   localparam int LOCK_MIN = 200;
   // ==========================================================
   // Link edge sampler and counters
   logic [2:0] lk_r;
   logic [8:0] lock_r;
   logic [3:0] bst_r;
   logic       rise, dllr_r;
   assign rise = lk_r[1] & ~lk_r[2];
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         lk_r   <= 3'h0;
         lock_r <= 9'h000;
         bst_r  <= 4'h0;
         dllr_r <= 1'b0;
      end else begin
         lk_r <= {lk_r[1:0], I_LINK_CLK};
         dllr_r <= O_OPERATING_MODE[8];
         // Held at zero while the loop is off, restarted by a DLL reset.
         if (O_EXT_MODE_ONE[0] || (O_OPERATING_MODE[8] && !dllr_r))
            lock_r <= 9'h000;
         else if (rise && lock_r != 9'h1FF)
            lock_r <= lock_r + 9'h001;
         if (!O_BURST_VALID)
            bst_r <= 4'h0;
         else if (rise)
            bst_r <= bst_r + 4'h1;
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   a_strobe_mode: assert property ($stable(O_EXT_MODE_ONE)[*2] |->
      O_STROBE_DIFF == !O_EXT_MODE_ONE[10]) else $error("strobe mode");
   a_term_pin_off: assert property ((!I_TERMINATION_CONTROL)[*4] |->
      !O_TERM_ON) else $error("termination on with pin low");
   a_term_rtt_off: assert property ((O_EXT_MODE_ONE[2] == 1'b0 &&
      O_EXT_MODE_ONE[6] == 1'b0)[*2] |-> !O_TERM_ON)
      else $error("termination on with value zero");
   a_cke_low_hold: assert property ((!I_CKE)[*8] |=>
      $stable(O_OPERATING_MODE) && $stable(O_EXT_MODE_ONE) &&
      $stable(O_EXT_MODE_TWO)) else $error("register written while idle");
   a_burst_len: assert property ($fell(O_BURST_VALID) |-> bst_r ==
      ((O_OPERATING_MODE[2:0] == BL_EIGHT) ? 4'h4 : 4'h2))
      else $error("burst length wrong");
   a_early_pulse: assert property (O_READ_EARLY |=> !O_READ_EARLY)
      else $error("early read flag too long");
   a_early_locked: assert property (O_DLL_LOCKED &&
      $past(O_DLL_LOCKED, 4) |-> !O_READ_EARLY)
      else $error("early read flag while locked");
   a_lock_time: assert property ($rose(O_DLL_LOCKED) |->
      lock_r >= LOCK_MIN) else $error("lock too soon");
   a_dll_off_unlocked: assert property (O_EXT_MODE_ONE[0][*2] |->
      !O_DLL_LOCKED) else $error("locked with loop disabled");
   c_burst: cover property ($rose(O_BURST_VALID));
   c_early: cover property (O_READ_EARLY);
   c_lock: cover property ($rose(O_DLL_LOCKED));
endmodule

bind dmi_mode_prog dmi_chk_properties u_chk (.I_CORE_CLK(I_CORE_CLK),
   .I_RESET_N(I_RESET_N), .I_LINK_CLK(I_LINK_CLK), .I_CKE(I_CKE),
   .I_TERMINATION_CONTROL(I_TERMINATION_CONTROL),
   .O_OPERATING_MODE(O_OPERATING_MODE), .O_EXT_MODE_ONE(O_EXT_MODE_ONE),
   .O_EXT_MODE_TWO(O_EXT_MODE_TWO), .O_DLL_LOCKED(O_DLL_LOCKED),
   .O_STROBE_DIFF(O_STROBE_DIFF), .O_TERM_ON(O_TERM_ON),
   .O_BURST_VALID(O_BURST_VALID), .O_READ_EARLY(O_READ_EARLY));

// [tb/dmi_ctrl_model.sv]
// Purpose: Behavioural memory controller driving the command pins.
// Assumes: Pin changes land on core clock edges.
// Notes:   Deselected cycles show the inverse of the last command.
`timescale 1ns/1ps
module dmi_ctrl_model
   import dmi_pkg::*;
(
   input  wire logic i_clk,
   output logic      o_link_clk,
   output logic      o_cke,
   output logic      o_term,
   output dmi_cmd_t  o_cmd
);
   // ==========================================================
   // Link clock of eight core clocks
   logic [2:0] ph_r = 3'h0;
   initial begin
      o_link_clk = 1'b0;
      o_cke      = 1'b0;
      o_term     = 1'b0;
      o_cmd      = '1;
   end
   always @(posedge i_clk) begin
      ph_r       <= ph_r + 3'h1;
      o_link_clk <= ph_r[2];
   end
   // ==========================================================
   // Changes at falling link edges so pins are settled at the rise.
   task automatic issue(input dmi_cmd_t c, input int gap);
      repeat (gap + 1) @(negedge o_link_clk);
      o_cmd <= c;
      @(negedge o_link_clk);
      o_cmd <= {1'b1, ~c[21:0]};
   endtask
   task automatic pins(input logic cke, input logic term);
      @(negedge o_link_clk);
      o_cke  <= cke;
      o_term <= term;
   endtask
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the mode-programming block.
// Assumes: The controller model drives every command pin.
// Notes:   The full power-up wait is run; it costs only 4000 clocks.
`timescale 1ns/1ps
module testbench;
   import dmi_pkg::*;
   logic        clk, rst_n, lclk, cke, term, locked, sdiff, ton, bv, bw, ap;
   logic        early, cke_m;
   dmi_cmd_t    cmd;
   logic [15:0] mode, e1o, e2o, row, mr, e1, e2, mrv, rowv, colv;
   logic [11:0] col;
   logic [2:0]  bank, b;
   int          bad_count = 0, compares = 0, cyc = 0, early_n = 0;
   int          seed = 32'h592e;
   dmi_ctrl_model u_ctrl (.i_clk(clk), .o_link_clk(lclk), .o_cke(cke),
      .o_term(term), .o_cmd(cmd));
   dmi_mode_prog u_dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
      .I_LINK_CLK(lclk), .I_CKE(cke), .I_TERMINATION_CONTROL(term),
      .I_CMD(cmd), .O_OPERATING_MODE(mode), .O_EXT_MODE_ONE(e1o),
      .O_EXT_MODE_TWO(e2o), .O_DLL_LOCKED(locked), .O_STROBE_DIFF(sdiff),
      .O_TERM_ON(ton), .O_BURST_VALID(bv), .O_BURST_WRITE(bw),
      .O_BURST_BANK(bank), .O_BURST_ROW(row), .O_BURST_COL(col),
      .O_AUTO_PRECHARGE(ap), .O_READ_EARLY(early));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // Checking tasks
   task automatic stop_test;
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk({15'h0, g}, {15'h0, e});
   endtask
   // Command code is {row strobe, column strobe, write enable}, low active.
   task automatic send(input logic [2:0] k, input logic [2:0] ba,
                       input logic [15:0] a);
      u_ctrl.issue({1'b0, k, ba, a}, 0);
      repeat (3) @(posedge clk);
   endtask
   task automatic mw(input logic [1:0] ba, input logic [15:0] v);
      send(3'h0, {1'b0, ba}, v);
      if (cke_m && ba == BANK_MAIN) mr = v;
      if (cke_m && ba == BANK_EXT1) e1 = v;
      if (cke_m && ba == BANK_EXT2) e2 = v;
      chk(mode, mr);
      chk(e1o, e1);
      chk(e2o, e2);
      chk_bit(sdiff, !e1[10]);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (early === 1'b1) early_n++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      cke_m = 1'b0;
      mr = 16'h0000;
      e1 = 16'h0001;
      e2 = 16'h0000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(mode, mr);
      chk(e1o, e1);
      chk(e2o, e2);
      chk_bit(sdiff, 1'b1);
      repeat (4000) @(posedge clk);
      u_ctrl.pins(1'b1, 1'b0);
      cke_m = 1'b1;
      u_ctrl.issue({1'b0, 3'h2, 3'h0, 16'h0400}, 2);
      mrv = 16'($random(seed));
      mw(BANK_EXT2, {8'h00, mrv[7], 7'h00});
      mw(BANK_EXT3, 16'h0000);
      mw(BANK_EXT1, (16'($random(seed)) & 16'h0C7E) | 16'h0004);
      mrv = (16'($random(seed)) & 16'h0E78) | {13'h0, BL_FOUR};
      mw(BANK_MAIN, mrv | 16'h0100);
      send(3'h2, 3'h0, 16'h0400);
      repeat (2) send(3'h1, 3'h0, 16'h0000);
      mw(BANK_MAIN, mrv);
      chk_bit(locked, 1'b0);
      send(3'h3, 3'h1, 16'h0000);
      send(3'h5, 3'h1, 16'h0000);
      chk(16'(early_n), 16'h0001);
      u_ctrl.pins(1'b1, 1'b1);
      repeat (8) @(posedge clk);
      chk_bit(ton, 1'b1);
      u_ctrl.pins(1'b1, 1'b0);
      for (int i = 0; i < 3000 && locked !== 1'b1; i++) @(posedge clk);
      chk_bit(locked, 1'b1);
      send(3'h2, 3'h0, 16'h0400);
      mw(BANK_EXT1, e1 | 16'h0380);
      mw(BANK_EXT1, e1 & ~16'h0380);
      for (int i = 0; i < 2; i++) begin
         mw(BANK_MAIN, {mrv[15:3], (i == 0) ? BL_EIGHT : BL_FOUR});
         b = 3'($random(seed));
         rowv = 16'($random(seed));
         colv = 16'($random(seed));
         send(3'h3, b, rowv);
         send((i == 0) ? 3'h4 : 3'h5, b, colv);
         chk_bit(bv, 1'b1);
         chk_bit(bw, i == 0);
         chk({13'h0, bank}, {13'h0, b});
         chk(row, rowv);
         chk({5'h0, col[11], col[9:0]}, {5'h0, colv[11], colv[9:0]});
         chk_bit(ap, colv[10]);
         repeat (40) @(posedge clk);
         send(3'h2, 3'h0, 16'h0400);
      end
      chk(16'(early_n), 16'h0001);
      // Refresh with clock enable dropping at the same edge: self refresh.
      fork
         u_ctrl.issue({1'b0, 3'h1, 3'h0, 16'h0000}, 0);
         u_ctrl.pins(1'b0, 1'b1);
      join
      repeat (8) @(posedge clk);
      chk_bit(ton, 1'b0);
      u_ctrl.pins(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      chk_bit(locked, 1'b0);
      u_ctrl.pins(1'b0, 1'b0);
      cke_m = 1'b0;
      mw(BANK_MAIN, 16'h0E72);
      stop_test();
   end
endmodule
